// File: design/lpiw_pkg.sv
// Package: power modes, route positions and sizes for the low-power interconnect
package lpiw_pkg;

  typedef enum logic [2:0] {
    LPIW_MODE_RUN,
    LPIW_MODE_SLEEP,
    LPIW_MODE_LP_RUN,
    LPIW_MODE_LP_SLEEP,
    LPIW_MODE_STOP
  } lpiw_mode_t;

  // Oscillator requester positions
  localparam int REQ_SERIAL  = 0;
  localparam int REQ_LP_SER  = 1;
  localparam int REQ_I2C     = 2;
  localparam int REQ_LPTIM   = 3;
  localparam int NUM_REQ     = 4;

  // Serial receiver positions
  localparam int SER_FULL    = 0;
  localparam int SER_LOW     = 1;
  localparam int NUM_SER     = 2;

  localparam int NUM_TIMERS  = 3;
  localparam int NUM_CLKSRC  = 5;
  localparam int NUM_GPIO    = 8;
  localparam int SYNC_DEPTH  = 3;

endpackage

// File: design/lpiw_osc_if.sv
// Interface: oscillator request and grant between arbiter and top
`timescale 1ns/100ps
interface lpiw_osc_if #(parameter int N = 4);
  logic [N-1:0] req;
  logic         in_stop;
  logic         osc_en;
  logic [N-1:0] gate;
  modport arb (input req, input in_stop, output osc_en, output gate);
  modport top (output req, output in_stop, input osc_en, input gate);
endinterface

// File: design/lpiw_osc_arb.sv
// Module: on-demand oscillator arbiter with per-requester clock gating
`timescale 1ns/100ps
module lpiw_osc_arb #(
  parameter int N = lpiw_pkg::NUM_REQ
) (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic reset_i,
  input  wire logic ce_i,
  // Requests and grants
  lpiw_osc_if.arb   osc
);

  typedef struct packed {
    logic         osc_en;
    logic [N-1:0] gate;
  } lpiw_arb_state_t;

  lpiw_arb_state_t st;
  lpiw_arb_state_t next_st;

  // Refused at elaboration: an arbiter with no requester has nothing to gate
  if (N < 1) begin : g_bad_n
    $error("lpiw_osc_arb: N must be at least 1");
  end

  always_comb begin
    next_st = st;
    // Oscillator runs while any requester holds its line, no software step
    next_st.osc_en = |osc.req;
    // In Stop only the requesters see the clock; outside Stop the clock tree owns it
    next_st.gate   = osc.in_stop ? osc.req : '0;
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      st <= '0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign osc.osc_en = st.osc_en;
  assign osc.gate   = st.gate;

endmodule

// File: design/lpiw_top.sv
// Module: low-power interconnect router with Stop-mode wakeup handling
// Functional notes
// - Timer-to-timer trigger blocked only in Stop
// - RTC wakeup triggers aux timer, not Stop
// - RTC event triggers low-power timer always
// - Clock source to timer channel, not Stop
// - GPIO routes; only low-power timer in Stop
// - Wakeup peripheral request starts oscillator automatically
// - Oscillator clock gated to requester only
// - Oscillator off when request removed
// - Serial start bit in Stop raises wakeup
// - Low serial on crystal, oscillator if crystal not ok; full needs oscillator
// - I2C address match in Stop raises wakeup
// - I2C reception in Stop requests oscillator
`timescale 1ns/100ps
module lpiw_top #(
  parameter int NT = lpiw_pkg::NUM_TIMERS,
  parameter int NC = lpiw_pkg::NUM_CLKSRC,
  parameter int NG = lpiw_pkg::NUM_GPIO
) (
  // Clock, reset, enable
  input  wire logic                 clk_sys_i,
  input  wire logic                 reset_i,
  input  wire logic                 ce_i,
  // Power mode
  input  wire lpiw_pkg::lpiw_mode_t mode_i,
  // Timer trigger sources and selection
  input  wire logic [NT-1:0]        general_timer_trgo_i,
  input  wire logic [$clog2(NT)-1:0] timer_trig_sel_i,
  output logic      [NT-1:0]        general_timer_trig_o,
  // RTC events
  input  wire logic                 auto_wakeup_event_i,
  input  wire logic                 rtc_event_i,
  output logic                      aux_two_channel_timer_trig_o,
  output logic                      low_power_timer_rtc_trig_o,
  // Clock sources for measurement
  input  wire logic [NC-1:0]        clk_src_i,
  input  wire logic [$clog2(NC)-1:0] clk_src_sel_i,
  output logic                      general_timer_meas_o,
  // GPIO routes
  input  wire logic [NG-1:0]        gpio_i,
  output logic      [NG-1:0]        general_timer_gpio_o,
  output logic      [NG-1:0]        low_power_timer_gpio_o,
  output logic                      adc_start_trig_o,
  // Serial and I2C wakeup sources
  input  wire logic [1:0]           serial_rx_i,
  input  wire logic [1:0]           serial_match_i,
  input  wire logic                 low_speed_external_osc_ok_i,
  input  wire logic                 i2c_addr_match_i,
  input  wire logic                 i2c_rx_busy_i,
  input  wire logic                 low_power_timer_osc_req_i,
  output logic      [1:0]           serial_wakeup_o,
  output logic                      i2c_wakeup_o,
  // Oscillator control
  output logic                      high_speed_internal_osc_en_o,
  output logic      [3:0]           high_speed_internal_osc_gate_o
);

  localparam int SD = lpiw_pkg::SYNC_DEPTH;

  // ------------------------------------------------------------
  // Parameter checks
  // ------------------------------------------------------------
  // Timer chaining needs a source other than the destination itself
  if (NT < 2) begin : g_bad_nt
    $error("lpiw_top: at least two timers needed");
  end
  if (NC < 2) begin : g_bad_nc
    $error("lpiw_top: at least two clock sources needed");
  end
  if (NG < 1) begin : g_bad_ng
    $error("lpiw_top: at least one GPIO needed");
  end
  // The settle check reads the last two stages of each chain
  if (SD < 3) begin : g_bad_sd
    $error("lpiw_top: pin chains need three stages");
  end

  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------
  function automatic logic is_stop(input lpiw_pkg::lpiw_mode_t m);
    return m == lpiw_pkg::LPIW_MODE_STOP;
  endfunction

  function automatic logic is_active(input lpiw_pkg::lpiw_mode_t m);
    return (m == lpiw_pkg::LPIW_MODE_RUN) || (m == lpiw_pkg::LPIW_MODE_SLEEP) ||
           (m == lpiw_pkg::LPIW_MODE_LP_RUN) || (m == lpiw_pkg::LPIW_MODE_LP_SLEEP);
  endfunction

  // A level counts only once the last two stages agree; a lone stage may still be settling
  function automatic logic settle(input logic late2, input logic late3, input logic held);
    return (late2 == late3) ? late3 : held;
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [SD-1:0] rx0_sync;
    logic [SD-1:0] rx1_sync;
    logic [NG-1:0] gpio_lvl;
    logic [1:0]    rx_prev;
    logic [NG-1:0] gpio_s1;
    logic [NG-1:0] gpio_s2;
    logic [NG-1:0] gpio_s3;
    logic [NT-1:0] tim_trig;
    logic          aux_trig;
    logic          lpt_rtc;
    logic          meas;
    logic [NG-1:0] gt_gpio;
    logic [NG-1:0] lpt_gpio;
    logic          adc_trig;
    logic [1:0]    ser_wk;
    logic          i2c_wk;
    logic          full_ser_req;
  } lpiw_state_t;

  lpiw_state_t st;
  lpiw_state_t next_st;

  // ------------------------------------------------------------
  // Oscillator arbiter
  // ------------------------------------------------------------
  lpiw_osc_if #(.N(lpiw_pkg::NUM_REQ)) osc_bus ();

  logic stop_now;
  logic act_now;
  assign stop_now = is_stop(mode_i);
  assign act_now  = is_active(mode_i);

  // Full serial port keeps the oscillator for frame wakeup; low port asks for it on a match only while the crystal is not ok
  assign osc_bus.req[lpiw_pkg::REQ_SERIAL] = st.full_ser_req;
  assign osc_bus.req[lpiw_pkg::REQ_LP_SER] = stop_now & serial_match_i[lpiw_pkg::SER_LOW]
                                             & ~low_speed_external_osc_ok_i;
  // Held for the whole reception, released when busy falls
  assign osc_bus.req[lpiw_pkg::REQ_I2C]    = stop_now & i2c_rx_busy_i;
  assign osc_bus.req[lpiw_pkg::REQ_LPTIM]  = stop_now & low_power_timer_osc_req_i;
  assign osc_bus.in_stop                   = stop_now;

  lpiw_osc_arb #(
    .N (lpiw_pkg::NUM_REQ)
  ) u_arb (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .ce_i      (ce_i),
    .osc       (osc_bus.arb)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  logic          rx0_fall;
  logic          rx1_fall;
  logic [NG-1:0] gpio_ok;

  always_comb begin
    next_st = st;
    // Pin inputs: three stages; a change counts when stages two and three agree
    next_st.rx0_sync = {st.rx0_sync[SD-2:0], serial_rx_i[lpiw_pkg::SER_FULL]};
    next_st.rx1_sync = {st.rx1_sync[SD-2:0], serial_rx_i[lpiw_pkg::SER_LOW]};
    next_st.gpio_s1  = gpio_i;
    next_st.gpio_s2  = st.gpio_s1;
    next_st.gpio_s3  = st.gpio_s2;
    // Stable level only where the last two stages agree, else hold previous
    for (int i = 0; i < NG; i++) begin
      gpio_ok[i] = settle(st.gpio_s2[i], st.gpio_s3[i], st.gpio_lvl[i]);
    end
    next_st.gpio_lvl   = gpio_ok;
    next_st.rx_prev[0] = settle(st.rx0_sync[SD-2], st.rx0_sync[SD-1], st.rx_prev[0]);
    next_st.rx_prev[1] = settle(st.rx1_sync[SD-2], st.rx1_sync[SD-1], st.rx_prev[1]);
    rx0_fall = st.rx_prev[0] & ~settle(st.rx0_sync[SD-2], st.rx0_sync[SD-1], st.rx_prev[0]);
    rx1_fall = st.rx_prev[1] & ~settle(st.rx1_sync[SD-2], st.rx1_sync[SD-1], st.rx_prev[1]);

    // Timer chaining: each timer takes the selected other timer's output
    for (int i = 0; i < NT; i++) begin
      next_st.tim_trig[i] = act_now && (int'(timer_trig_sel_i) != i) &&
                            (int'(timer_trig_sel_i) < NT) &&
                            general_timer_trgo_i[timer_trig_sel_i];
    end
    next_st.aux_trig = act_now & auto_wakeup_event_i;
    next_st.lpt_rtc  = (act_now | stop_now) & rtc_event_i;
    // Out-of-range selection reads zero rather than an undefined source
    next_st.meas     = act_now && (int'(clk_src_sel_i) < NC) &&
                       clk_src_i[clk_src_sel_i];
    next_st.gt_gpio  = act_now ? gpio_ok : '0;
    next_st.lpt_gpio = (act_now | stop_now) ? gpio_ok : '0;
    next_st.adc_trig = act_now & gpio_ok[0];

    // Start-bit wakeup, one-cycle pulse per falling edge seen in Stop
    next_st.ser_wk[lpiw_pkg::SER_FULL] = stop_now & rx0_fall;
    next_st.ser_wk[lpiw_pkg::SER_LOW]  = stop_now & rx1_fall;
    next_st.i2c_wk = stop_now & i2c_addr_match_i;
    // Full-port start bit wakes the oscillator; it stays until the frame match is reported or Stop is left
    // A fresh start bit beats a match in the same cycle: the new frame still needs the clock
    if (!stop_now) begin
      next_st.full_ser_req = 1'b0;
    end else if (rx0_fall) begin
      next_st.full_ser_req = 1'b1;
    end else if (serial_match_i[lpiw_pkg::SER_FULL]) begin
      next_st.full_ser_req = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      st          <= '0;
      st.rx0_sync <= '1;
      st.rx1_sync <= '1;
      st.rx_prev  <= '1;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign general_timer_trig_o           = st.tim_trig;
  assign aux_two_channel_timer_trig_o   = st.aux_trig;
  assign low_power_timer_rtc_trig_o     = st.lpt_rtc;
  assign general_timer_meas_o           = st.meas;
  assign general_timer_gpio_o           = st.gt_gpio;
  assign low_power_timer_gpio_o         = st.lpt_gpio;
  assign adc_start_trig_o               = st.adc_trig;
  assign serial_wakeup_o                = st.ser_wk;
  assign i2c_wakeup_o                   = st.i2c_wk;
  assign high_speed_internal_osc_en_o   = osc_bus.osc_en;
  assign high_speed_internal_osc_gate_o = osc_bus.gate;

endmodule

// File: bench/lpiw_partner.sv
// Partner: serial senders that face the wakeup logic
`timescale 1ns/100ps
module lpiw_partner (
  // Clock
  input  wire logic       clk_sys_i,
  // Frame requests from the bench
  input  wire logic [1:0] send_i,
  // Receive lines toward the block
  output logic      [1:0] serial_rx_o
);
  // Start bit held low for BIT_LEN cycles, then the line returns to its idle high
  localparam int BIT_LEN = 4;
  int cnt [2] = '{0, 0};
  initial serial_rx_o = 2'h3;
  // Requests are taken on the rising edge so a falling-edge request cannot race the model
  always @(posedge clk_sys_i) begin
    for (int p = 0; p < 2; p++) begin
      if (send_i[p] && cnt[p] == 0) begin
        cnt[p]         <= 2 * BIT_LEN;
        serial_rx_o[p] <= 1'b0;
      end else if (cnt[p] > 0) begin
        cnt[p]         <= cnt[p] - 1;
        serial_rx_o[p] <= !(cnt[p] - 1 > BIT_LEN);
      end else begin
        serial_rx_o[p] <= 1'b1;
      end
    end
  end
endmodule

// File: bench/lpiw_top_checker.sv
// Checker: port-level assertions for the low-power interconnect
`timescale 1ns/100ps
module lpiw_top_checker #(
  parameter int NT = 3,
  parameter int NC = 5,
  parameter int NG = 8
) (
  // Clock, reset, enable, mode
  input wire logic                 clk_sys_i,
  input wire logic                 reset_i,
  input wire logic                 ce_i,
  input wire lpiw_pkg::lpiw_mode_t mode_i,
  // Routes
  input wire logic [NT-1:0]        general_timer_trig_o,
  input wire logic                 auto_wakeup_event_i,
  input wire logic                 rtc_event_i,
  input wire logic                 aux_two_channel_timer_trig_o,
  input wire logic                 low_power_timer_rtc_trig_o,
  input wire logic                 general_timer_meas_o,
  input wire logic [NG-1:0]        gpio_i,
  input wire logic [NG-1:0]        general_timer_gpio_o,
  input wire logic [NG-1:0]        low_power_timer_gpio_o,
  // Wakeup and oscillator
  input wire logic                 i2c_addr_match_i,
  input wire logic                 i2c_rx_busy_i,
  input wire logic                 low_power_timer_osc_req_i,
  input wire logic [1:0]           serial_wakeup_o,
  input wire logic                 i2c_wakeup_o,
  input wire logic                 high_speed_internal_osc_en_o,
  input wire logic [3:0]           high_speed_internal_osc_gate_o
);
  localparam lpiw_pkg::lpiw_mode_t STP = lpiw_pkg::LPIW_MODE_STOP;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  wire stp = mode_i == STP;
  wire act = mode_i < STP;
  a_rtc_lptim_route: assert property (ce_i && stp |=> low_power_timer_rtc_trig_o == $past(rtc_event_i))
    else $error("rtc route to low-power timer lost");
  a_aux_route: assert property (ce_i |=> aux_two_channel_timer_trig_o == $past(auto_wakeup_event_i && act))
    else $error("aux timer trigger wrong for mode");
  a_timer_block: assert property (ce_i && stp |=> general_timer_trig_o == '0 && !general_timer_meas_o)
    else $error("timer path open in stop");
  // Pin routes pass a sync chain, so only a settled pin is judged
  a_gpio_stop: assert property ((ce_i && stp && $stable(gpio_i))[*5] |=>
    general_timer_gpio_o == '0 && low_power_timer_gpio_o == $past(gpio_i)) else $error("gpio routing wrong in stop");
  a_osc_req: assert property (ce_i && stp && (i2c_rx_busy_i || low_power_timer_osc_req_i) |=>
    high_speed_internal_osc_en_o) else $error("oscillator not started");
  a_gate_owner: assert property (ce_i |=> high_speed_internal_osc_gate_o[3:2] ==
    $past({low_power_timer_osc_req_i, i2c_rx_busy_i} & {2{stp}})) else $error("clock gate wrong");
  a_osc_or_gate: assert property ($past(ce_i && stp) |->
    high_speed_internal_osc_en_o == |high_speed_internal_osc_gate_o) else $error("oscillator not OR of requests");
  a_i2c_wake: assert property (ce_i |=> i2c_wakeup_o == $past(i2c_addr_match_i && stp))
    else $error("i2c wakeup wrong");
  a_ser_pulse: assert property (ce_i && serial_wakeup_o[0] |=> !serial_wakeup_o[0])
    else $error("serial wakeup longer than one cycle");
  c_i2c_osc: cover property (stp && i2c_rx_busy_i ##1 high_speed_internal_osc_en_o);
  c_ser_wake: cover property (serial_wakeup_o[0]);
  c_gpio_stop: cover property (stp && low_power_timer_gpio_o != '0);
endmodule
bind lpiw_top lpiw_top_checker #(.NT(NT), .NC(NC), .NG(NG)) chk_u (.*);

// File: bench/lpiw_top_bench.sv
// Testbench: self-checking scenarios for the low-power interconnect
`timescale 1ns/100ps
module lpiw_top_bench;
  localparam lpiw_pkg::lpiw_mode_t STP = lpiw_pkg::LPIW_MODE_STOP;
  logic clk_sys_i = 0, reset_i = 1, ce_i = 1, auto_wakeup_event_i = 0, rtc_event_i = 0;
  logic low_speed_external_osc_ok_i = 1, i2c_addr_match_i = 0, i2c_rx_busy_i = 0, low_power_timer_osc_req_i = 0;
  logic aux_two_channel_timer_trig_o, low_power_timer_rtc_trig_o, general_timer_meas_o, adc_start_trig_o;
  logic i2c_wakeup_o, high_speed_internal_osc_en_o;
  lpiw_pkg::lpiw_mode_t mode_i = lpiw_pkg::LPIW_MODE_RUN;
  logic [2:0] general_timer_trgo_i = 3'h2, general_timer_trig_o, clk_src_sel_i = 3'h3;
  logic [1:0] timer_trig_sel_i = 2'h1, serial_rx_i, serial_match_i = 2'h0, serial_wakeup_o, send = 2'h0;
  logic [4:0] clk_src_i = 5'h08;
  logic [7:0] gpio_i = 8'h00, general_timer_gpio_o, low_power_timer_gpio_o;
  logic [3:0] high_speed_internal_osc_gate_o;
  int error_cnt = 0, check_count = 0;
  lpiw_top dut_u (.*);
  lpiw_partner peer_u (.clk_sys_i(clk_sys_i), .send_i(send), .serial_rx_o(serial_rx_i));
  always #4 clk_sys_i = !clk_sys_i;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic t_routes();
    auto_wakeup_event_i = 1;
    rtc_event_i = 1;
    // Code 5 is no mode at all: every route must stay closed
    for (int m = 0; m < 6; m++) begin
      mode_i = lpiw_pkg::lpiw_mode_t'(m);
      cyc(1);
      chk(8'(general_timer_trig_o), m < 4 ? 8'h05 : 8'h00);
      chk(8'(aux_two_channel_timer_trig_o), 8'(m < 4));
      chk(8'(low_power_timer_rtc_trig_o), 8'(m < 5));
      chk(8'(general_timer_meas_o), 8'(m < 4));
    end
    auto_wakeup_event_i = 0;
    rtc_event_i = 0;
  endtask
  task automatic t_gpio();
    for (int m = 3; m < 5; m++) begin
      mode_i = lpiw_pkg::lpiw_mode_t'(m);
      gpio_i = (m < 4) ? 8'hA5 : 8'h5B;
      cyc(6);
      chk(general_timer_gpio_o, m < 4 ? gpio_i : 8'h00);
      chk(low_power_timer_gpio_o, gpio_i);
      chk(8'(adc_start_trig_o), 8'(m < 4));
    end
  endtask
  task automatic t_i2c_osc();
    mode_i = STP;
    i2c_rx_busy_i = 1;
    low_power_timer_osc_req_i = 1;
    cyc(1);
    chk(8'(high_speed_internal_osc_gate_o), 8'h0C);
    i2c_rx_busy_i = 0;
    i2c_addr_match_i = 1;
    cyc(1);
    chk(8'({high_speed_internal_osc_en_o, high_speed_internal_osc_gate_o}), 8'h18);
    chk(8'(i2c_wakeup_o), 8'h01);
    low_power_timer_osc_req_i = 0;
    mode_i = lpiw_pkg::LPIW_MODE_RUN;
    cyc(1);
    chk(8'({i2c_wakeup_o, high_speed_internal_osc_en_o}), 8'h00);
    i2c_addr_match_i = 0;
  endtask
  task automatic t_serial();
    int n;
    mode_i = STP;
    send = 2'h3;
    cyc(1);
    send = 2'h0;
    n = 0;
    while (serial_wakeup_o[0] !== 1'h1 && n < 12) begin
      cyc(1);
      n++;
    end
    chk(8'(serial_wakeup_o), 8'h03);
    cyc(1);
    chk(8'({serial_wakeup_o, high_speed_internal_osc_en_o, high_speed_internal_osc_gate_o}), 8'h11);
    serial_match_i = 2'h1;
    cyc(1);
    serial_match_i = 2'h2;
    low_speed_external_osc_ok_i = 0;
    cyc(2);
    chk(8'(high_speed_internal_osc_gate_o), 8'h02);
    low_speed_external_osc_ok_i = 1;
    cyc(2);
    chk(8'(high_speed_internal_osc_en_o), 8'h00);
    serial_match_i = 2'h0;
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Whole run is under a hundred cycles; the limit leaves wide margin
  initial begin
    #200000;
    error_cnt++;
    finish_test();
  end
  initial begin
    cyc(12);
    reset_i = 0;
    cyc(1);
    t_routes();
    t_gpio();
    t_i2c_osc();
    t_serial();
    finish_test();
  end
endmodule
